// [adcc_pkg.sv]
// Purpose: constants, field layout and types of the converter control block
// Assumes: registers are 8-bit except the 12-bit limits, one per aligned 32-bit APB word
// Notes:   byte address of a register is four times its index
//
// How it works
// - wait modes keep block running, interrupts wake
// - halt modes stop block, no wake
// - flag and its enable raise interrupt
// - width code selects 12/10/8/6 bits
// - repeat bit restarts conversions back to back
// - start bit starts, self-clears after one tick
// - start during conversion is ignored
// - power bit zero means power-down
// - clock halver divides converter clock by two
// - trigger polarity: rise, fall or both
// - trigger source zero means software only
// - main channels sample time code table
// - extra channels use second sample field
// - monitored channel field, reset all ones
// - data-lost flag on unread result
// - window flag when monitored channel result outside limits
// - done flag, cleared by write, read, power-down
// - scan sets done flag after last channel
// - high byte holds upper result bits
// - reserved status and high bits read zero
// - low byte holds low result bits
// - limits compared, masked to selected width

package adcc_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_CONV_CONTROL = 6'h00;
    localparam logic [5:0] IDX_TRIG_TIMING = 6'h01;
    localparam logic [5:0] IDX_MON_SAMPLE = 6'h02;
    localparam logic [5:0] IDX_CONV_FLAGS = 6'h03;
    localparam logic [5:0] IDX_RESULT_HIGH = 6'h04;
    localparam logic [5:0] IDX_RESULT_LOW = 6'h05;
    localparam logic [5:0] IDX_UPPER_LIMIT = 6'h06;
    localparam logic [5:0] IDX_LOWER_LIMIT = 6'h07;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CC_POWER = 0;
    localparam int CC_START = 1;
    localparam int CC_REPEAT = 2;
    localparam int CC_DONE_IE = 3;
    localparam int CC_WIN_IE = 4;
    localparam int CC_WIDTH_LO = 5;
    localparam int CC_LOST_IE = 7;
    localparam int TT_SMP_LO = 0;
    localparam int TT_SRC_LO = 3;
    localparam int TT_POL_LO = 5;
    localparam int TT_HALVE = 7;
    localparam int MS_MONITORED_CHANNEL_SELECT_LO = 0;
    localparam int MS_SMP_LO = 5;
    localparam int FL_DONE = 0;
    localparam int FL_WIN = 1;
    localparam int FL_LOST = 2;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CONV_CONTROL = 8'h00;
    localparam logic [7:0] RST_TRIG_TIMING = 8'h00;
    localparam logic [7:0] RST_MON_SAMPLE = 8'h1f;
    localparam logic [11:0] RST_UPPER = 12'hfff;
    localparam logic [11:0] RST_LOWER = 12'h000;
    localparam logic [1:0] WID_12 = 2'h0;
    localparam logic [1:0] WID_10 = 2'h1;
    localparam logic [1:0] WID_8 = 2'h2;
    localparam logic [1:0] WID_6 = 2'h3;
    localparam logic [1:0] SRC_SOFT = 2'h0;
    localparam logic [1:0] POL_RISE = 2'h1;
    localparam logic [1:0] POL_FALL = 2'h2;
    localparam logic [1:0] POL_BOTH = 2'h3;
    localparam logic [4:0] FIRST_EXTRA_CH = 5'h18;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } adcc_apb_req_t;

    typedef struct packed {
        logic done;
        logic last;
        logic [4:0] channel;
        logic [11:0] result;
    } adcc_core_in_t;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_addr(input logic [5:0] idx);
        reg_addr = {idx, 2'h0};
    endfunction

    function automatic logic [8:0] sample_cycles(input logic [2:0] code);
        unique case (code)
            3'h0: sample_cycles = 9'h004;
            3'h1: sample_cycles = 9'h009;
            3'h2: sample_cycles = 9'h010;
            3'h3: sample_cycles = 9'h018;
            3'h4: sample_cycles = 9'h030;
            3'h5: sample_cycles = 9'h060;
            3'h6: sample_cycles = 9'h0c0;
            3'h7: sample_cycles = 9'h180;
        endcase
    endfunction

    function automatic logic [11:0] width_mask(input logic [1:0] w);
        unique case (w)
            WID_12: width_mask = 12'hfff;
            WID_10: width_mask = 12'h3ff;
            WID_8: width_mask = 12'h0ff;
            WID_6: width_mask = 12'h03f;
        endcase
    endfunction

endpackage

// [adcc_sample_timer.sv]
// Purpose: converter clock enable and sampling window counter
// Assumes: one system clock; converter clock is an enable pulse
// Notes:   counts converter ticks, not system cycles

`timescale 1ns/100ps
`default_nettype none

module adcc_sample_timer (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // control
    input wire logic i_halve,
    input wire logic i_run,
    input wire logic i_start,
    input wire logic [8:0] i_cycles,
    // status
    output logic o_tick,
    output logic o_done
);

    logic phase_reg;
    logic [8:0] count_reg;

    // ------------------------------------------------------------
    // converter clock enable
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !i_run) begin
            phase_reg <= 1'b0;
        end else begin
            phase_reg <= ~phase_reg;
        end
    end

    assign o_tick = i_run && (!i_halve || phase_reg);

    // ------------------------------------------------------------
    // sampling window
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            count_reg <= 9'h000;
        end else if (i_start) begin
            count_reg <= i_cycles;
        end else if (o_tick && count_reg != 9'h000) begin
            count_reg <= count_reg - 9'h001;
        end
    end

    assign o_done = o_tick && count_reg == 9'h001 && !i_start;

endmodule

`default_nettype wire

// [adcc_ctrl.sv]
// Purpose: control, status and result registers of the converter
// Assumes: analog core and DMA on i_clk_sys; triggers are async pins
// Notes:   APB slave answers in the first access cycle
//
// Our own choice: the APB register port.

`timescale 1ns/100ps
`default_nettype none

module adcc_ctrl (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // apb slave
    input wire adcc_pkg::adcc_apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // analog core
    input wire adcc_pkg::adcc_core_in_t i_core,
    input wire logic i_dma_read,
    output logic o_core_power,
    output logic [1:0] o_core_width,
    output logic o_core_sample,
    output logic o_core_convert,
    // external triggers
    input wire logic [2:0] i_ext_trig,
    // low power and interrupt
    input wire logic i_lp_wait,
    input wire logic i_lp_halt,
    output logic o_irq,
    output logic o_wake
);
    import adcc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SAMPLE,
        ST_CONVERT
    } adcc_state_t;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] control_reg, timing_reg, monitor_reg;
    logic [7:0] high_byte, low_byte, rd_mux;
    logic [2:0] flags_reg, flags_next, smp_code;
    logic [2:0] trig_meta_reg, trig_sync_reg, trig_prev_reg;
    logic [3:0] trig_now, trig_then;
    logic [11:0] result_reg, upper_reg, lower_reg, mask, value;
    logic [5:0] acc_idx;
    adcc_state_t state_reg;
    logic unread_reg, setup, wr_acc, rd_acc, mapped, powered, run;
    logic tick, sample_done, begin_sample, trig_hit, trig_level;
    logic trig_old, busy, outside, watched, rd_low, finish, another;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign setup = i_apb.psel && !i_apb.penable;
    assign wr_acc = i_apb.psel && i_apb.penable && o_pready && i_apb.pwrite
        && mapped;
    assign rd_acc = i_apb.psel && i_apb.penable && o_pready && !i_apb.pwrite
        && mapped;
    assign acc_idx = i_apb.paddr[7:2];
    assign mapped = i_apb.paddr[1:0] == 2'h0
        && acc_idx <= IDX_LOWER_LIMIT;
    assign rd_low = rd_acc && i_apb.paddr == reg_addr(IDX_RESULT_LOW);

    // ------------------------------------------------------------
    // derived controls
    // ------------------------------------------------------------
    assign powered = control_reg[CC_POWER];
    assign run = !i_lp_halt;
    assign busy = state_reg != ST_IDLE;
    assign mask = width_mask(control_reg[CC_WIDTH_LO +: 2]);
    assign value = i_core.result & mask;
    // the core reports the channel for the next window before it starts
    assign smp_code = (i_core.channel >= FIRST_EXTRA_CH)
        ? monitor_reg[MS_SMP_LO +: 3]
        : timing_reg[TT_SMP_LO +: 3];
    assign outside = value > (upper_reg & mask)
        || value < (lower_reg & mask);
    assign watched = i_core.channel == monitor_reg[MS_MONITORED_CHANNEL_SELECT_LO +: 5];
    assign finish = state_reg == ST_CONVERT && i_core.done && run;
    // later channels of a scan, or repeat mode, keep the core busy
    assign another = finish && powered
        && (!i_core.last || control_reg[CC_REPEAT]);
    assign begin_sample = (state_reg == ST_IDLE && tick && powered
        && control_reg[CC_START]) || another;

    // ------------------------------------------------------------
    // converter clock and sampling window
    // ------------------------------------------------------------
    adcc_sample_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst || !powered),
        .i_halve(timing_reg[TT_HALVE]),
        .i_run(run),
        .i_start(begin_sample),
        .i_cycles(sample_cycles(smp_code)),
        .o_tick(tick),
        .o_done(sample_done)
    );

    // ------------------------------------------------------------
    // trigger synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            trig_meta_reg <= 3'h0;
            trig_sync_reg <= 3'h0;
            trig_prev_reg <= 3'h0;
        end else begin
            trig_meta_reg <= i_ext_trig;
            trig_sync_reg <= trig_meta_reg;
            trig_prev_reg <= trig_sync_reg;
        end
    end

    // lane 0 is constant low: source code 00 never triggers
    assign trig_now = {trig_sync_reg, 1'b0};
    assign trig_then = {trig_prev_reg, 1'b0};
    assign trig_level = trig_now[timing_reg[TT_SRC_LO +: 2]];
    assign trig_old = trig_then[timing_reg[TT_SRC_LO +: 2]];

    always_comb begin
        unique case (timing_reg[TT_POL_LO +: 2])
            POL_RISE: trig_hit = trig_level && !trig_old;
            POL_FALL: trig_hit = !trig_level && trig_old;
            POL_BOTH: trig_hit = trig_level != trig_old;
            default: trig_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // conversion control register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            control_reg <= RST_CONV_CONTROL;
        end else begin
            if (wr_acc && acc_idx == IDX_CONV_CONTROL) begin
                control_reg <= i_apb.pwdata[7:0];
                // a start while busy is dropped, never queued
                control_reg[CC_START] <= i_apb.pwdata[CC_START]
                    && !busy && run;
            end else if (trig_hit && !busy && run && powered) begin
                control_reg[CC_START] <= 1'b1;
            end else if (tick) begin
                control_reg[CC_START] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            timing_reg <= RST_TRIG_TIMING;
            monitor_reg <= RST_MON_SAMPLE;
            upper_reg <= RST_UPPER;
            lower_reg <= RST_LOWER;
        end else if (wr_acc) begin
            // sample fields are not guarded while busy
            if (acc_idx == IDX_TRIG_TIMING) begin
                timing_reg <= i_apb.pwdata[7:0];
            end
            if (acc_idx == IDX_MON_SAMPLE) begin
                monitor_reg <= i_apb.pwdata[7:0];
            end
            if (acc_idx == IDX_UPPER_LIMIT) begin
                upper_reg <= i_apb.pwdata[11:0];
            end
            if (acc_idx == IDX_LOWER_LIMIT) begin
                lower_reg <= i_apb.pwdata[11:0];
            end
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !powered) begin
            state_reg <= ST_IDLE;
            o_core_sample <= 1'b0;
            o_core_convert <= 1'b0;
        end else begin
            o_core_convert <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (begin_sample) begin
                        state_reg <= ST_SAMPLE;
                        o_core_sample <= 1'b1;
                    end
                end
                ST_SAMPLE: begin
                    if (sample_done) begin
                        state_reg <= ST_CONVERT;
                        o_core_sample <= 1'b0;
                        o_core_convert <= 1'b1;
                    end
                end
                ST_CONVERT: begin
                    if (another) begin
                        state_reg <= ST_SAMPLE;
                        o_core_sample <= 1'b1;
                    end else if (finish) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // result and unread tracking
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            result_reg <= 12'h000;
        end else if (finish) begin
            result_reg <= value;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !powered) begin
            unread_reg <= 1'b0;
        end else if (finish) begin
            unread_reg <= 1'b1;
        end else if (i_dma_read || rd_low) begin
            unread_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        if (wr_acc && acc_idx == IDX_CONV_FLAGS) begin
            // ones written leave a flag as it is
            flags_next = flags_reg & i_apb.pwdata[2:0];
        end
        if (rd_low) begin
            flags_next[FL_DONE] = 1'b0;
        end
        // hardware set placed last so it wins over any clear
        if (finish && i_core.last) begin
            flags_next[FL_DONE] = 1'b1;
        end
        if (finish && watched && outside) begin
            flags_next[FL_WIN] = 1'b1;
        end
        if (finish && unread_reg && !i_dma_read) begin
            flags_next[FL_LOST] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst || !powered) begin
            flags_reg <= 3'h0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------
    // interrupt and wake
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_irq <= run && ((flags_reg[FL_DONE] && control_reg[CC_DONE_IE])
                || (flags_reg[FL_WIN] && control_reg[CC_WIN_IE])
                || (flags_reg[FL_LOST] && control_reg[CC_LOST_IE]));
            o_wake <= o_irq && i_lp_wait && run;
        end
    end

    // ------------------------------------------------------------
    // core drive
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_core_power <= 1'b0;
            o_core_width <= WID_12;
        end else begin
            o_core_power <= powered;
            o_core_width <= control_reg[CC_WIDTH_LO +: 2];
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        unique case (control_reg[CC_WIDTH_LO +: 2])
            WID_12: high_byte = {4'h0, result_reg[11:8]};
            WID_10: high_byte = {6'h00, result_reg[9:8]};
            default: high_byte = 8'h00;
        endcase
        low_byte = (control_reg[CC_WIDTH_LO +: 2] == WID_6)
            ? {2'h0, result_reg[5:0]} : result_reg[7:0];
    end

    always_comb begin
        unique case (acc_idx)
            IDX_CONV_CONTROL: rd_mux = control_reg;
            IDX_TRIG_TIMING: rd_mux = timing_reg;
            IDX_MON_SAMPLE: rd_mux = monitor_reg;
            IDX_CONV_FLAGS: rd_mux = {5'h00, flags_reg};
            IDX_RESULT_HIGH: rd_mux = high_byte;
            IDX_RESULT_LOW: rd_mux = low_byte;
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // apb answer, one wait-free access cycle
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0000_0000;
        end else begin
            o_pready <= setup;
            o_pslverr <= setup && !mapped;
            if (setup) begin
                if (!mapped) begin
                    o_prdata <= 32'h0000_0000;
                end else if (acc_idx == IDX_UPPER_LIMIT) begin
                    o_prdata <= {20'h00000, upper_reg};
                end else if (acc_idx == IDX_LOWER_LIMIT) begin
                    o_prdata <= {20'h00000, lower_reg};
                end else begin
                    o_prdata <= {24'h000000, rd_mux};
                end
            end
        end
    end

endmodule

`default_nettype wire

// [adcc_properties.sv]
// Purpose: port level checks of adcc_ctrl
// Assumes: one clock domain, sync reset
// Notes: bound to every adcc_ctrl instance
`timescale 1ns/100ps
`default_nettype none

module adcc_properties (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // apb
    input wire adcc_pkg::adcc_apb_req_t i_apb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    // core and power
    input wire logic o_core_sample,
    input wire logic o_core_convert,
    input wire logic i_lp_wait,
    input wire logic i_lp_halt,
    input wire logic o_irq,
    input wire logic o_wake
);
    import adcc_pkg::*;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_srst);

    property p_ready; i_apb.psel && !i_apb.penable |=> o_pready; endproperty
    a_ready: assert property (p_ready) else $error("ready missing");
    property p_err; o_pready && (|i_apb.paddr[7:5] || |i_apb.paddr[1:0])
        |-> o_pslverr; endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_rsv_flags; o_pready && !i_apb.pwrite && i_apb.paddr == 8'h0c
        |-> o_prdata[31:3] == 29'h0; endproperty
    a_rsv_flags: assert property (p_rsv_flags) else $error("flag rsv");
    property p_rsv_high; o_pready && !i_apb.pwrite && i_apb.paddr == 8'h10
        |-> o_prdata[31:4] == 28'h0; endproperty
    a_rsv_high: assert property (p_rsv_high) else $error("high rsv");
    property p_smp_min; $rose(o_core_sample) |-> o_core_sample[*4]; endproperty
    a_smp_min: assert property (p_smp_min) else $error("short window");
    property p_cnv; o_core_convert |-> !o_core_sample ##1 !o_core_convert;
    endproperty
    a_cnv: assert property (p_cnv) else $error("convert pulse");
    property p_halt; i_lp_halt [*2] |-> !o_irq && !o_wake; endproperty
    a_halt: assert property (p_halt) else $error("active in halt");
    property p_wake; o_irq && i_lp_wait && !i_lp_halt |=> o_wake; endproperty
    a_wake: assert property (p_wake) else $error("no wake");

    c_wake: cover property (o_wake);
    c_smp: cover property ($rose(o_core_sample));
    c_err: cover property (o_pslverr);
endmodule

bind adcc_ctrl adcc_properties i_props (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .i_apb(i_apb), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_core_sample(o_core_sample), .o_core_convert(o_core_convert),
    .i_lp_wait(i_lp_wait), .i_lp_halt(i_lp_halt), .o_irq(o_irq),
    .o_wake(o_wake));
`default_nettype wire

// [adcc_core_model.sv]
// Purpose: analog core stand-in for adcc_ctrl
// Assumes: one conversion at a time, delay set by bench
// Notes: result lines scrambled outside the done pulse
`timescale 1ns/100ps
`default_nettype none

module adcc_core_model (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_srst,
    // from block and bench
    input wire logic i_convert,
    input wire logic [7:0] i_delay,
    input wire logic [4:0] i_chan,
    input wire logic [11:0] i_value,
    // to block
    output var adcc_pkg::adcc_core_in_t o_core
);
    import adcc_pkg::*;
    logic busy_reg;
    logic done_reg;
    logic [7:0] cnt_reg;
    always_ff @(posedge i_clk_sys) begin
        done_reg <= 1'b0;
        if (i_srst) begin
            busy_reg <= 1'b0;
        end else if (i_convert) begin
            busy_reg <= 1'b1;
            cnt_reg <= i_delay;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg - 8'h01;
            busy_reg <= cnt_reg != 8'h00;
            done_reg <= cnt_reg == 8'h00;
        end
    end
    // a stale result must not pass for a fresh one
    assign o_core = '{done: done_reg, last: done_reg, channel: i_chan,
        result: done_reg ? i_value : ~i_value};
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: register level test of adcc_ctrl
// Assumes: core model answers after a set delay
// Notes: expectations follow the field layout
`timescale 1ns/100ps
`default_nettype none

module tb;
    import adcc_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    adcc_apb_req_t apb = '0;
    adcc_core_in_t core;
    logic [31:0] prdata, slen, last_len, n_conv, n0;
    logic pready, pslverr, smp, cnv, lpw, lph, irq, wake;
    logic [2:0] trig = 3'h0;
    logic [7:0] dly = 8'h05;
    logic [4:0] chan = 5'h03;
    logic [11:0] val = 12'habc;
    logic [31:0] tab [3] = '{32'h01030309, 32'h80030308, 32'h00a31860};
    int fail_count = 0;
    int n_checks = 0;
    always #12.5 clk = ~clk;
    adcc_ctrl i_dut (.i_clk_sys(clk), .i_srst(srst), .i_apb(apb),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_core(core), .i_dma_read(1'b0), .o_core_power(),
        .o_core_width(), .o_core_sample(smp), .o_core_convert(cnv),
        .i_ext_trig(trig), .i_lp_wait(lpw), .i_lp_halt(lph),
        .o_irq(irq), .o_wake(wake));
    adcc_core_model i_core (.i_clk_sys(clk), .i_srst(srst),
        .i_convert(cnv), .i_delay(dly), .i_chan(chan), .i_value(val),
        .o_core(core));
    // window length of the last finished sampling
    always @(posedge clk) begin
        n_conv <= srst ? 32'h0 : n_conv + {31'h0, cnv};
        slen <= smp ? slen + 32'h1 : 32'h0;
        if (!smp && slen != 32'h0) last_len <= slen;
    end
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int k;
        apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        apb.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        apb <= '0;
        if (k >= 50) begin
            fail_count++;
            finish_test();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk({31'h0, e}, {31'h0, |a[1:0] || a >= 8'h20});
    endtask
    task automatic wait_done;
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!core.done && k < 3000);
        if (k >= 3000) begin
            fail_count++;
            finish_test();
        end
        repeat (3) @(posedge clk);
    endtask
    initial begin
        lpw = 1'b0;
        lph = 1'b0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) rd(8'(i * 4), i == 2 ? 32'h1f : 32'h0);
        rd(8'h40, 32'h0);
        rd(8'h0d, 32'h0);
        wr(8'h0c, 32'hff);
        rd(8'h0c, 32'h0);
        wr(8'h00, 32'h01);
        for (int w = 0; w < 4; w++) begin
            wr(8'h00, {24'h0, 1'b0, 2'(w), 5'h0b});
            wait_done();
            chk({31'h0, irq}, 32'h1);
            rd(8'h00, {24'h0, 1'b0, 2'(w), 5'h09});
            rd(8'h0c, 32'h1);
            rd(8'h10, w == 0 ? val[11:8] : w == 1 ? val[9:8] : 32'h0);
            rd(8'h14, w == 3 ? val[5:0] : val[7:0]);
            rd(8'h0c, 32'h0);
        end
        wr(8'h00, 32'h0b);
        wait_done();
        lpw <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, wake}, 32'h1);
        lph <= 1'b1;
        repeat (3) @(posedge clk);
        chk({30'h0, irq, wake}, 32'h0);
        lph <= 1'b0;
        lpw <= 1'b0;
        wr(8'h08, 32'h03);
        wr(8'h18, 32'h100);
        wr(8'h00, 32'h13);
        wait_done();
        rd(8'h0c, 32'h07);
        wr(8'h0c, 32'h0);
        rd(8'h0c, 32'h0);
        wr(8'h18, 32'hfff);
        foreach (tab[i]) begin
            wr(8'h04, tab[i][31:24]);
            wr(8'h08, tab[i][23:16]);
            chan <= tab[i][12:8];
            wr(8'h00, 32'h03);
            wait_done();
            chk(last_len, tab[i][7:0]);
        end
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        dly <= 8'd100;
        n0 = n_conv;
        wr(8'h00, 32'h03);
        wr(8'h00, 32'h03);
        wait_done();
        chk(n_conv - n0, 32'h1);
        wr(8'h00, 32'h87);
        wait_done();
        wait_done();
        rd(8'h0c, 32'h05);
        chk({31'h0, irq}, 32'h1);
        wr(8'h00, 32'h80);
        rd(8'h0c, 32'h0);
        n0 = n_conv;
        wr(8'h00, 32'h02);
        repeat (20) @(posedge clk);
        chk(n_conv - n0, 32'h0);
        dly <= 8'h05;
        chan <= 5'h03;
        wr(8'h00, 32'h01);
        for (int p = 0; p < 5; p++) begin
            wr(8'h04, {25'h0, p == 4 ? 2'h3 : 2'(p), p == 4 ? 2'h0 : 2'h1, 3'h0});
            n0 = n_conv;
            trig[0] <= 1'b1;
            repeat (40) @(posedge clk);
            trig[0] <= 1'b0;
            repeat (40) @(posedge clk);
            chk(n_conv - n0, p == 3 ? 2 : (p == 0 || p == 4) ? 0 : 1);
        end
        finish_test();
    end
endmodule
`default_nettype wire
